// ---- core/ifbs_pkg.sv ----
// Package: constants and carriers for interrupt fast bank select
package ifbs_pkg;
   localparam int IFBS_NUM_REGS = 4;
   localparam int IFBS_FIELDS = 8;
   localparam int IFBS_NUM_W = 8;
   // Register byte offsets on the bus
   localparam logic [7:0] IFBS_OFS_CHOICE0 = 8'h00;
   localparam logic [7:0] IFBS_OFS_CHOICE1 = 8'h04;
   localparam logic [7:0] IFBS_OFS_CHOICE2 = 8'h08;
   localparam logic [7:0] IFBS_OFS_CHOICE3 = 8'h0C;
   localparam logic [7:0] IFBS_OFS_STATUS = 8'h10;
   localparam logic [15:0] IFBS_CHOICE_RESET = 16'h0000;
   localparam logic [15:0] IFBS_PSW_RESET = 16'h0000;
   // Processor status word field positions
   localparam int IFBS_PSW_BANK_LSB = 8;
   localparam int IFBS_PSW_LVL_LSB = 12;
   // Priority thresholds
   localparam logic [3:0] IFBS_FAST_MIN_LVL = 4'hC;
   localparam logic [3:0] IFBS_MAX_LVL = 4'hF;
   // Bank codes
   localparam logic [1:0] IFBS_BANK_GLOBAL = 2'h0;
   localparam logic [1:0] IFBS_BANK_RSVD = 2'h1;
   localparam logic [1:0] IFBS_BANK_LOCAL1 = 2'h2;
   localparam logic [1:0] IFBS_BANK_LOCAL2 = 2'h3;
   // AXI responses
   localparam logic [1:0] IFBS_RESP_OKAY = 2'h0;
   localparam logic [1:0] IFBS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      IFBS_ENTRY_INT = 2'h0,
      IFBS_ENTRY_HWTRAP = 2'h1,
      IFBS_ENTRY_SWTRAP = 2'h2
   } ifbs_entry_kind_t;

   typedef struct packed {
      ifbs_entry_kind_t kind;
      logic [3:0] cpu_priority_level;
      logic [2:0] group_priority_level;
      logic [IFBS_NUM_W-1:0] number;
   } ifbs_entry_req_t;
endpackage

// ---- core/ifbs_bank_select.sv ----
// Fast register bank selection on exception entry, with AXI4-Lite registers
// What this block does
// RL1: Programmed bank choice is used only for normal interrupts of level 12+.
// RL2: Each level 15..12 with each group 7..0 has its own 2-bit bank choice.
// RL3: Choices live in four 16-bit registers of eight fields, field 7 on top.
// RL4: Registers 2 and 3 exist only with the extended group option.
// RL5: Codes: 00 global, 01 reserved, 10 local bank 1, 11 local bank 2.
// RL6: On fast entry the selected choice is copied into the status word bank.
// RL7: Levels 15/14 use reg 3 for groups 7..4, reg 1 else; 13/12 regs 2 and 0.
// RL8: Levels 15/13 use fields 4..7, 14/12 fields 0..3, index group mod 4.
// RL9: All choice registers reset to zero, so the global bank is used.
// RL10: A software trap takes its vector entry from the trap number operand.
// RL11: Hardware trap entry always selects the global bank.
// RL12: Software trap entry keeps the bank field and priority level unchanged.
// RL13: The status word bank field sits in bits 9 to 8.
// RL14: Interrupts below level 12 enter with the global bank, no lookup.
`timescale 1ns/1ps
module ifbs_bank_select #(
   parameter bit EXT_GROUP_OPT = 1'b1
) (
   input wire logic clk, // 25 MHz clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic entry_valid, // Entry request pulse
   input wire ifbs_pkg::ifbs_entry_req_t entry_req, // Entry request
   input wire logic psw_load, // Core loads status word
   input wire logic [15:0] psw_load_data, // Value to load
   output logic [15:0] processor_status_word, // Status word
   output logic entry_done, // Entry applied pulse
   output logic [ifbs_pkg::IFBS_NUM_W-1:0] vector_index, // Vector entry
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);
   import ifbs_pkg::*;

   logic [15:0] bank_choice_reg [IFBS_NUM_REGS];
   logic [15:0] next_bank_choice_reg [IFBS_NUM_REGS];
   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [7:0] aw_addr, next_aw_addr;
   logic [15:0] w_data, next_w_data;
   logic [1:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [15:0] next_psw;
   logic next_entry_done;
   logic [IFBS_NUM_W-1:0] next_vector_index;
   logic [1:0] last_bank, next_last_bank;
   logic [1:0] sel_reg;
   logic [2:0] sel_field;
   logic [1:0] sel_code;
   logic fast_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Register index check, absent registers count as unmapped
   function automatic logic reg_exists(input logic [7:0] addr,
                                       output logic [1:0] idx);
      logic ok;
      ok = 1'b0;
      idx = addr[3:2];
      if (addr[7:4] == 4'h0 && addr[1:0] == 2'h0) begin
         ok = (addr[3] == 1'b0) || EXT_GROUP_OPT; // [RL4]
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write channel
   always_comb begin
      logic [1:0] widx;
      logic wok;
      widx = 2'h0;
      wok = 1'b0;
      for (int i = 0; i < IFBS_NUM_REGS; i++) begin
         next_bank_choice_reg[i] = bank_choice_reg[i];
      end
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata[15:0];
         next_w_strb = s_axi_wstrb[1:0];
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
         wok = reg_exists(aw_addr, widx);
         if (wok) begin
            for (int b = 0; b < 2; b++) begin
               if (w_strb[b]) begin
                  next_bank_choice_reg[widx][b*8 +: 8] = w_data[b*8 +: 8];
               end
            end
         end
         next_bresp = wok ? IFBS_RESP_OKAY : IFBS_RESP_SLVERR;
         next_bvalid = 1'b1;
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
      end
      next_awready = !next_aw_full;
      next_wready = !next_w_full;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < IFBS_NUM_REGS; i++) begin
            bank_choice_reg[i] <= IFBS_CHOICE_RESET; // [RL9]
         end
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full <= 1'b0;
         w_data <= 16'h0000;
         w_strb <= 2'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IFBS_RESP_OKAY;
      end else begin
         bank_choice_reg <= next_bank_choice_reg;
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   always_comb begin
      logic [1:0] ridx;
      logic rok;
      ridx = 2'h0;
      rok = 1'b0;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rok = reg_exists(s_axi_araddr, ridx);
         next_rvalid = 1'b1;
         next_rresp = IFBS_RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (rok) begin
            next_rdata[15:0] = bank_choice_reg[ridx];
         end else if (s_axi_araddr == IFBS_OFS_STATUS) begin
            next_rdata[1:0] = last_bank;
         end else begin
            next_rresp = IFBS_RESP_SLVERR;
         end
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= IFBS_RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bank lookup and entry handling
   always_comb begin
      sel_reg = {entry_req.group_priority_level[2],
                 entry_req.cpu_priority_level[1]}; // [RL7]
      sel_field = {entry_req.cpu_priority_level[0],
                   entry_req.group_priority_level[1:0]}; // [RL8]
      sel_code = bank_choice_reg[sel_reg][sel_field*2 +: 2]; // [RL2] [RL3]
      if (!EXT_GROUP_OPT && sel_reg[1]) begin
         sel_code = IFBS_BANK_GLOBAL; // [RL4]
      end
      fast_ok = entry_req.cpu_priority_level >= IFBS_FAST_MIN_LVL; // [RL1]
   end

   always_comb begin
      next_psw = processor_status_word;
      next_entry_done = 1'b0;
      next_vector_index = vector_index;
      next_last_bank = last_bank;
      if (psw_load) begin
         next_psw = psw_load_data;
      end
      if (entry_valid) begin
         next_entry_done = 1'b1;
         next_vector_index = entry_req.number; // [RL10]
         unique case (entry_req.kind)
            IFBS_ENTRY_INT: begin
               next_psw[IFBS_PSW_LVL_LSB +: 4] = entry_req.cpu_priority_level;
               // Codes pass through unchanged, 01 included [RL5]
               next_psw[IFBS_PSW_BANK_LSB +: 2] =
                  fast_ok ? sel_code : IFBS_BANK_GLOBAL; // [RL6] [RL13] [RL14]
            end
            IFBS_ENTRY_HWTRAP: begin
               next_psw[IFBS_PSW_LVL_LSB +: 4] = IFBS_MAX_LVL;
               next_psw[IFBS_PSW_BANK_LSB +: 2] = IFBS_BANK_GLOBAL; // [RL11]
            end
            IFBS_ENTRY_SWTRAP: begin
               next_psw = processor_status_word; // [RL12]
            end
            default: begin
               next_entry_done = 1'b0;
            end
         endcase
         next_last_bank = next_psw[IFBS_PSW_BANK_LSB +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         processor_status_word <= IFBS_PSW_RESET;
         entry_done <= 1'b0;
         vector_index <= '0;
         last_bank <= IFBS_BANK_GLOBAL;
      end else begin
         processor_status_word <= next_psw;
         entry_done <= next_entry_done;
         vector_index <= next_vector_index;
         last_bank <= next_last_bank;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_low_level_global: assert property ( // [RL14]
      entry_valid && entry_req.kind == IFBS_ENTRY_INT && !psw_load &&
      entry_req.cpu_priority_level < IFBS_FAST_MIN_LVL
      |=> processor_status_word[9:8] == IFBS_BANK_GLOBAL)
      else $error("low level entry did not select global bank");
   a_fast_bank_copy: assert property ( // [RL6]
      entry_valid && entry_req.kind == IFBS_ENTRY_INT && fast_ok
      |=> processor_status_word[9:8] == $past(sel_code))
      else $error("fast entry bank differs from choice");
   a_hw_trap_bank: assert property ( // [RL11]
      entry_valid && entry_req.kind == IFBS_ENTRY_HWTRAP
      |=> processor_status_word[9:8] == IFBS_BANK_GLOBAL &&
          processor_status_word[15:12] == IFBS_MAX_LVL)
      else $error("hardware trap entry wrong bank or level");
   a_sw_trap_keep: assert property ( // [RL12]
      entry_valid && entry_req.kind == IFBS_ENTRY_SWTRAP
      |=> $stable(processor_status_word[15:8]))
      else $error("software trap changed bank or level");
   a_sw_trap_vector: assert property ( // [RL10]
      entry_valid && entry_req.kind inside {IFBS_ENTRY_INT,
                                            IFBS_ENTRY_HWTRAP,
                                            IFBS_ENTRY_SWTRAP}
      |=> vector_index == $past(entry_req.number) && entry_done)
      else $error("vector entry not taken from trap number");
   a_top_field_map: assert property ( // [RL7]
      entry_valid && entry_req.kind == IFBS_ENTRY_INT &&
      entry_req.cpu_priority_level == IFBS_MAX_LVL &&
      entry_req.group_priority_level == 3'h7 && EXT_GROUP_OPT
      |=> processor_status_word[9:8] == $past(bank_choice_reg[3][15:14]))
      else $error("level 15 group 7 not from top field of reg 3");
   a_low_field_map: assert property ( // [RL8]
      entry_valid && entry_req.kind == IFBS_ENTRY_INT &&
      entry_req.cpu_priority_level == IFBS_FAST_MIN_LVL &&
      entry_req.group_priority_level == 3'h0
      |=> processor_status_word[9:8] == $past(bank_choice_reg[0][1:0]))
      else $error("level 12 group 0 not from field 0 of reg 0");
   a_absent_regs: assert property ( // [RL4]
      !EXT_GROUP_OPT |-> bank_choice_reg[2] == IFBS_CHOICE_RESET &&
                         bank_choice_reg[3] == IFBS_CHOICE_RESET)
      else $error("absent choice register was written");
   a_write_resp: assert property ( // [RL3]
      aw_full && w_full && !s_axi_bvalid
      |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write response or ready not raised after both taken");
endmodule // ifbs_bank_select

// ---- test/ifbs_core_model.sv ----
// Core-side model: issues exception entries and status word loads
`timescale 1ns/1ps
module ifbs_core_model (
   input wire logic clk, // Core clock
   output logic entry_valid, // Entry request pulse
   output ifbs_pkg::ifbs_entry_req_t entry_req, // Entry request
   output logic psw_load, // Status word load
   output logic [15:0] psw_load_data // Value to load
);
   import ifbs_pkg::*;
   initial begin
      entry_valid = 1'b0;
      entry_req = '0;
      psw_load = 1'b0;
      psw_load_data = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // One-cycle pulse; idle lines flip so stale values never look valid
   task automatic enter(input ifbs_entry_kind_t kind, input logic [3:0] lvl,
      input logic [2:0] grp, input logic [7:0] num);
      @(posedge clk);
      entry_valid <= 1'b1;
      entry_req <= '{kind, lvl, grp, num};
      @(posedge clk);
      entry_valid <= 1'b0;
      entry_req <= ~entry_req;
   endtask
   task automatic load(input logic [15:0] v);
      @(posedge clk);
      psw_load <= 1'b1;
      psw_load_data <= v;
      @(posedge clk);
      psw_load <= 1'b0;
      psw_load_data <= ~v;
   endtask
endmodule // ifbs_core_model

// ---- test/ifbs_bank_select_tb.sv ----
// Testbench: register access and bank selection on exception entry
`timescale 1ns/1ps
module ifbs_bank_select_tb;
   import ifbs_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic entry_valid, psw_load, entry_done, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   ifbs_entry_req_t entry_req;
   logic [15:0] psw_load_data, processor_status_word;
   logic [7:0] vector_index, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, got;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [1:0] min_bresp, min_rresp, resp_min, psw_bank;
   logic [15:0] min_psw;
   logic [31:0] min_rdata, got_min;
   logic [15:0] regs [4];
   int miscompares = 0, check_count = 0;
   int r, f;
   always #20 clk = ~clk;
   ifbs_core_model u_core (.clk, .entry_valid, .entry_req, .psw_load,
      .psw_load_data);
   ifbs_bank_select #(.EXT_GROUP_OPT(1'b1)) u_dut (.clk, .sys_rst,
      .entry_valid, .entry_req, .psw_load, .psw_load_data,
      .processor_status_word, .entry_done, .vector_index, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // Build without the extended group option: regs 2 and 3 are absent
   ifbs_bank_select #(.EXT_GROUP_OPT(1'b0)) u_dut_min (.clk, .sys_rst,
      .entry_valid, .entry_req, .psw_load, .psw_load_data,
      .processor_status_word(min_psw), .entry_done(), .vector_index(),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(min_bresp),
      .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready(), .s_axi_rdata(min_rdata), .s_axi_rresp(min_rresp),
      .s_axi_rvalid(), .s_axi_rready);
   assign psw_bank = processor_status_word[9:8];
   ////////////////////////////////////////////////////////////////////////
   task automatic check_word(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_resp(input string what, input logic [1:0] exp,
      input logic [1:0] seen);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Ready is registered, so its value at the falling edge is what the
   // next rising edge samples
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic aw_hs, w_hs, b_hs;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid;
         resp = s_axi_bresp;
         resp_min = min_bresp;
         @(posedge clk);
         if (aw_hs)
            s_axi_awvalid <= 1'b0;
         if (w_hs)
            s_axi_wvalid <= 1'b0;
      end while (!b_hs);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a);
      logic ar_hs, r_hs;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         r_hs = s_axi_rvalid;
         got = s_axi_rdata;
         got_min = min_rdata;
         resp_min = min_rresp;
         resp = s_axi_rresp;
         @(posedge clk);
         if (ar_hs)
            s_axi_arvalid <= 1'b0;
      end while (!r_hs);
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [1:0] exp_bank(input int lvl, input int grp);
      int ri, fi;
      if (lvl < 12)
         return IFBS_BANK_GLOBAL;
      ri = (grp >= 4 ? 2 : 0) + (lvl >= 14 ? 1 : 0);
      fi = (lvl % 2 == 1 ? 4 : 0) + grp % 4;
      return regs[ri][2*fi +: 2];
   endfunction
   task automatic do_entry(input ifbs_entry_kind_t k, input int lvl,
      input int grp, input logic [7:0] num);
      u_core.enter(k, 4'(lvl), 3'(grp), num);
      @(negedge clk);
      check_word("entry done", 32'h1, 32'(entry_done));
      check_word("vector index", 32'(num), 32'(vector_index));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (r = 0; r < 4; r++) begin
         axi_read(8'(4 * r));
         check_word("choice reset", 32'h0000_0000, got);
      end
      axi_read(8'h14);
      check_resp("unmapped read", IFBS_RESP_SLVERR, resp);
      axi_write(8'h14, 32'h0000_FFFF, 4'hF);
      check_resp("unmapped write", IFBS_RESP_SLVERR, resp);
      regs = '{16'hE41B, 16'h1BE4, 16'h72D8, 16'h8D27};
      for (r = 0; r < 4; r++) begin
         axi_write(8'(4 * r), {16'hFFFF, regs[r]}, 4'hF);
         check_resp("write resp", IFBS_RESP_OKAY, resp);
         check_resp("min write resp",
            r < 2 ? IFBS_RESP_OKAY : IFBS_RESP_SLVERR, resp_min);
      end
      axi_write(IFBS_OFS_CHOICE0, 32'h0000_00FF, 4'h1);
      regs[0][7:0] = 8'hFF;
      for (r = 0; r < 4; r++) begin
         axi_read(8'(4 * r));
         check_word("choice readback", {16'h0000, regs[r]}, got);
         check_word("min readback",
            r < 2 ? {16'h0000, regs[r]} : 32'h0000_0000, got_min);
         check_resp("min read resp",
            r < 2 ? IFBS_RESP_OKAY : IFBS_RESP_SLVERR, resp_min);
      end
      // Every level and group pairing in the fast range
      for (r = 12; r < 16; r++)
         for (f = 0; f < 8; f++) begin
            do_entry(IFBS_ENTRY_INT, r, f, 8'(r * 8 + f));
            check_word("bank", 32'(exp_bank(r, f)),
               32'(psw_bank));
            check_word("level", r,
               32'(processor_status_word[15:12]));
            check_word("min bank", f >= 4 ? 32'h0 : 32'(exp_bank(r, f)),
               32'(min_psw[9:8]));
         end
      axi_read(IFBS_OFS_STATUS);
      check_word("status", 32'(exp_bank(15, 7)), got);
      do_entry(IFBS_ENTRY_INT, 11, 3, 8'h5A);
      check_word("low bank", 32'h0, 32'(psw_bank));
      do_entry(IFBS_ENTRY_INT, 15, 7, 8'h7F);
      do_entry(IFBS_ENTRY_HWTRAP, 3, 7, 8'h04);
      check_word("trap bank", 32'h0, 32'(psw_bank));
      check_word("trap level", 32'hF,
         32'(processor_status_word[15:12]));
      u_core.load(16'hD200);
      @(negedge clk);
      check_word("loaded psw", 32'h0000_D200,
         32'(processor_status_word));
      do_entry(IFBS_ENTRY_SWTRAP, 12, 1, 8'h33);
      check_word("swtrap psw", 32'h0000_D200,
         32'(processor_status_word));
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule // ifbs_bank_select_tb
